// *** rtl/cfs_pkg.sv ***
// package: opcodes, completion codes, reader modes and state encoding
package cfs_pkg;

   // ==========================================================
   // word layout
   localparam int WORD_W      = 36;
   localparam int OP_HI       = 35;
   localparam int OP_LO       = 30;
   localparam int OP_W        = 6;
   localparam int CODE_HI     = 35;
   localparam int CODE_LO     = 32;
   localparam int CODE_W      = 4;
   localparam int INTR_BIT    = 3;    // low bit of the upper octal digit

   // ==========================================================
   // operation codes, non-interrupting form (interrupting sets INTR_BIT)
   localparam logic [5:0] OP_TERMINATE   = 6'h13;  // octal 23
   localparam logic [5:0] OP_XFER_NOFEED = 6'h21;  // octal 41
   localparam logic [5:0] OP_XFER_FILL   = 6'h22;  // octal 42
   localparam logic [5:0] OP_FEED_ONE    = 6'h23;  // octal 43
   localparam logic [5:0] OP_RDR_XLATE   = 6'h32;  // octal 62
   localparam logic [5:0] OP_RDR_COLUMN  = 6'h33;  // octal 63
   localparam logic [5:0] OP_RDR_ROW     = 6'h34;  // octal 64

   // ==========================================================
   // completion codes in completion_code_field
   localparam logic [3:0] CC_SYNC_SEQ    = 4'h4;   // 0100
   localparam logic [3:0] CC_SYNC_CNT    = 4'h6;   // 0110
   localparam logic [3:0] CC_NORMAL      = 4'h8;   // 1000
   localparam logic [3:0] CC_ILLEGAL_OP  = 4'ha;   // 1010
   localparam logic [3:0] CC_CHECK       = 4'hb;   // 1011
   localparam logic [3:0] CC_INAPPROP    = 4'hc;   // 1100
   localparam logic [3:0] CC_ILLEGAL_CHR = 4'he;   // 1110
   localparam logic [3:0] CC_INTERLOCK   = 4'hf;   // 1111

   // ==========================================================
   // buffer and feed figures
   localparam logic [2:0] INPUT_AREA_CARDS = 3'h3;
   localparam logic [2:0] FILL_TOTAL       = 3'h4;  // area plus one
   localparam logic [2:0] OWED_RESET       = 3'h0;

   // ==========================================================
   // reader format modes and controller states
   typedef enum logic [1:0]
   {
      CFS_MODE_XLATE  = 2'h0,
      CFS_MODE_COLUMN = 2'h1,
      CFS_MODE_ROW    = 2'h2
   } cfs_mode_type;

   typedef enum logic [2:0]
   {
      CFS_IDLE   = 3'h0,
      CFS_XFER   = 3'h1,
      CFS_FEED   = 3'h3,
      CFS_REPORT = 3'h2,
      CFS_HALT   = 3'h6
   } cfs_state_type;

endpackage

// *** rtl/cfs_unit.sv ***
// card unit function interpreter and status word generator
//
// How it works
// - terminate ends any operation in progress
// - transfer errors held until transfer completes
// - transfer without feed sends one card
// - words per card follow reader format mode
// - transfer with fill refills three-card area
// - empty buffer fill feeds four cards
// - single feed stores card, no transfer
// - single feed with cards owed feeds one
// - translate mode persists until next format
// - column/row modes; clear restores translate
// - interrupting form always gives status word
// - non-interrupting form gives status on error
// - completion code in bits 35 to 32
// - sequence, counter, normal, illegal op codes
// - check, inappropriate, character, interlock codes
// - error code wins over normal completion, except on terminate
// - improper sequence reports inappropriate code
// - odd upper octal digit means interrupting
// - non-interrupting error waits for terminate
`timescale 1ns/1ps
`default_nettype none

module cfs_unit
   import cfs_pkg::*;
#(
   parameter int WCNT_W        = 7,
   parameter int WORDS_XLATE   = 14,
   parameter int WORDS_COLUMN  = 27,
   parameter int WORDS_ROW     = 27
)
(
   input  wire logic                sys_clk,
   input  wire logic                rst_b,
   input  wire logic                panel_clear,
   input  wire logic                fn_strobe,
   input  wire logic [WORD_W-1:0]   fn_word,
   output logic                     out_req,
   output logic                     attention,
   output logic [WORD_W-1:0]        status_word,
   input  wire logic                status_ack,
   input  wire logic [2:0]          buf_cards,
   output logic                     xfer_start,
   output logic [WCNT_W-1:0]        xfer_words,
   input  wire logic                xfer_done,
   output logic                     feed_req,
   input  wire logic                feed_done,
   input  wire logic                err_event,
   input  wire logic [CODE_W-1:0]   err_code,
   output logic [1:0]               reader_mode,
   output logic [2:0]               cards_owed
);

   // ==========================================================
   // elaboration checks
   if (WORDS_XLATE < 1 || WORDS_XLATE >= (1 << WCNT_W) ||
       WORDS_COLUMN < 1 || WORDS_COLUMN >= (1 << WCNT_W) ||
       WORDS_ROW < 1 || WORDS_ROW >= (1 << WCNT_W))
   begin : g_bad_words
      $error("word counts must be nonzero and fit WCNT_W bits");
   end

   // ==========================================================
   // state record
   typedef struct packed
   {
      cfs_state_type        state;
      cfs_mode_type         mode;
      logic [2:0]           owed;
      logic                 feed_busy;
      logic                 intr;
      logic                 err_pend;
      logic [CODE_W-1:0]    err_code;
      logic [CODE_W-1:0]    code;
      logic                 xfer_start;
      logic [WCNT_W-1:0]    words;
      logic                 feed_req;
   } cfs_regs_type;

   cfs_regs_type regs_ff;
   cfs_regs_type nxt_regs;

   // ==========================================================
   // helpers
   // words per card for a reader format
   function automatic logic [WCNT_W-1:0] words_for(input cfs_mode_type m);
      logic [WCNT_W-1:0] w;
      w = WCNT_W'(WORDS_XLATE);
      case (m)
         CFS_MODE_COLUMN : w = WCNT_W'(WORDS_COLUMN);
         CFS_MODE_ROW    : w = WCNT_W'(WORDS_ROW);
         default         : w = WCNT_W'(WORDS_XLATE);
      endcase
      return w;
   endfunction

   // strip the interrupt bit to get the basic operation
   function automatic logic [OP_W-1:0] base_op(input logic [OP_W-1:0] op);
      logic [OP_W-1:0] b;
      b = op;
      b[INTR_BIT] = 1'b0;
      return b;
   endfunction

   // ==========================================================
   // decode of the presented function word
   logic [OP_W-1:0]  op_code;
   logic [OP_W-1:0]  op_base;
   logic             op_intr;
   logic             is_term;
   logic             take_fn;

   assign op_code = fn_word[OP_HI:OP_LO];
   assign op_base = base_op(op_code);
   assign op_intr = op_code[INTR_BIT];
   assign is_term = fn_strobe && (op_base == OP_TERMINATE);
   assign take_fn = fn_strobe && (regs_ff.state == CFS_IDLE) && !is_term;

   // ==========================================================
   // next-state logic
   always_comb
   begin
      nxt_regs            = regs_ff;
      nxt_regs.xfer_start = 1'b0;
      nxt_regs.feed_req   = 1'b0;

      // external errors are latched; first one kept until reported or a terminate clears it
      if (err_event && !regs_ff.err_pend)
      begin
         nxt_regs.err_pend = 1'b1;
         nxt_regs.err_code = err_code;
      end

      // background card feeds against the owed counter
      if (feed_done && regs_ff.feed_busy)
      begin
         nxt_regs.feed_busy = 1'b0;
         if (regs_ff.owed != 3'h0)
         begin
            nxt_regs.owed = regs_ff.owed - 3'h1;
         end
      end
      else if (!regs_ff.feed_busy && regs_ff.owed != 3'h0)
      begin
         nxt_regs.feed_req  = 1'b1;
         nxt_regs.feed_busy = 1'b1;
      end

      case (regs_ff.state)
         CFS_IDLE :
         begin
            if (take_fn)
            begin
               nxt_regs.intr = op_intr;
               nxt_regs.code = CC_NORMAL;
               case (op_base)
                  OP_XFER_NOFEED :
                  begin
                     if (buf_cards == 3'h0)
                     begin
                        nxt_regs.code  = CC_INAPPROP;
                        nxt_regs.state = CFS_REPORT;
                     end
                     else
                     begin
                        nxt_regs.xfer_start = 1'b1;
                        nxt_regs.words = words_for(regs_ff.mode);
                        nxt_regs.state = CFS_XFER;
                     end
                  end
                  OP_XFER_FILL :
                  begin
                     // refill after taking one card; four when empty
                     nxt_regs.owed = (buf_cards >= FILL_TOTAL) ?
                                     3'h0 : FILL_TOTAL - buf_cards;
                     nxt_regs.xfer_start = 1'b1;
                     nxt_regs.words = words_for(regs_ff.mode);
                     nxt_regs.state = CFS_XFER;
                  end
                  OP_FEED_ONE :
                  begin
                     if (regs_ff.owed != 3'h0)
                     begin
                        nxt_regs.owed  = 3'h1;
                        nxt_regs.state = CFS_FEED;
                     end
                     else if (buf_cards >= INPUT_AREA_CARDS)
                     begin
                        nxt_regs.code  = CC_INAPPROP;
                        nxt_regs.state = CFS_REPORT;
                     end
                     else
                     begin
                        nxt_regs.owed  = 3'h1;
                        nxt_regs.state = CFS_FEED;
                     end
                  end
                  OP_RDR_XLATE, OP_RDR_COLUMN, OP_RDR_ROW :
                  begin
                     case (op_base)
                        OP_RDR_COLUMN : nxt_regs.mode = CFS_MODE_COLUMN;
                        OP_RDR_ROW    : nxt_regs.mode = CFS_MODE_ROW;
                        default       : nxt_regs.mode = CFS_MODE_XLATE;
                     endcase
                     nxt_regs.state = op_intr ? CFS_REPORT : CFS_IDLE;
                  end
                  default :
                  begin
                     nxt_regs.code  = CC_ILLEGAL_OP;
                     nxt_regs.state = CFS_REPORT;
                  end
               endcase
               // a latched or same-cycle error outranks a normal ending
               if ((regs_ff.err_pend || err_event) &&
                   nxt_regs.code == CC_NORMAL &&
                   nxt_regs.state != CFS_XFER && nxt_regs.state != CFS_FEED)
               begin
                  nxt_regs.code     = regs_ff.err_pend ?
                                      regs_ff.err_code : err_code;
                  nxt_regs.err_pend = 1'b0;
                  nxt_regs.state    = CFS_REPORT;
               end
            end
            else if (regs_ff.err_pend && !fn_strobe)
            begin
               // error from background feeding, reported on its own
               nxt_regs.code     = regs_ff.err_code;
               nxt_regs.err_pend = 1'b0;
               nxt_regs.state    = CFS_REPORT;
            end
         end
         CFS_XFER :
         begin
            if (xfer_done)
            begin
               if (regs_ff.err_pend || err_event)
               begin
                  // deferred error shown only now, beating normal
                  nxt_regs.code     = regs_ff.err_pend ?
                                      regs_ff.err_code : err_code;
                  nxt_regs.err_pend = 1'b0;
                  nxt_regs.state    = CFS_REPORT;
               end
               else
               begin
                  nxt_regs.code  = CC_NORMAL;
                  nxt_regs.state = regs_ff.intr ? CFS_REPORT : CFS_IDLE;
               end
            end
         end
         CFS_FEED :
         begin
            if (regs_ff.err_pend || err_event)
            begin
               nxt_regs.code     = regs_ff.err_pend ?
                                   regs_ff.err_code : err_code;
               nxt_regs.err_pend = 1'b0;
               nxt_regs.state    = CFS_REPORT;
            end
            else if (regs_ff.owed == 3'h0 && !regs_ff.feed_busy)
            begin
               nxt_regs.code  = CC_NORMAL;
               nxt_regs.state = regs_ff.intr ? CFS_REPORT : CFS_IDLE;
            end
         end
         CFS_REPORT :
         begin
            if (status_ack)
            begin
               // non-interrupting error: stay silent until terminate
               nxt_regs.state = (!regs_ff.intr && regs_ff.code != CC_NORMAL) ?
                                CFS_HALT : CFS_IDLE;
            end
         end
         CFS_HALT :
         begin
            nxt_regs.state = CFS_HALT;
         end
         default :
         begin
            nxt_regs.state = CFS_IDLE;
         end
      endcase

      // terminate is taken in every state and wins over all else
      if (is_term)
      begin
         nxt_regs.owed      = OWED_RESET;
         nxt_regs.feed_busy = 1'b0;
         nxt_regs.feed_req  = 1'b0;
         nxt_regs.xfer_start = 1'b0;
         // an error raised in the terminate cycle is kept, not lost
         nxt_regs.err_pend  = err_event;
         nxt_regs.err_code  = err_event ? err_code : nxt_regs.err_code;
         nxt_regs.intr      = op_intr;
         nxt_regs.code      = CC_NORMAL;
         nxt_regs.state     = op_intr ? CFS_REPORT : CFS_IDLE;
      end

      // panel clear restores translate format
      if (panel_clear)
      begin
         nxt_regs.mode = CFS_MODE_XLATE;
      end
   end

   // ==========================================================
   // state register; reset acts as the processor master clear
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         regs_ff.state      <= CFS_IDLE;
         regs_ff.mode       <= CFS_MODE_XLATE;
         regs_ff.owed       <= OWED_RESET;
         regs_ff.feed_busy  <= 1'b0;
         regs_ff.intr       <= 1'b0;
         regs_ff.err_pend   <= 1'b0;
         regs_ff.err_code   <= CC_NORMAL;
         regs_ff.code       <= CC_NORMAL;
         regs_ff.xfer_start <= 1'b0;
         regs_ff.words      <= '0;
         regs_ff.feed_req   <= 1'b0;
      end
      else
      begin
         regs_ff <= nxt_regs;
      end
   end

   // ==========================================================
   // outputs
   assign out_req     = (regs_ff.state == CFS_IDLE);
   assign attention   = (regs_ff.state == CFS_REPORT);
   assign status_word = {regs_ff.code, {(WORD_W-CODE_W){1'b0}}};
   assign xfer_start  = regs_ff.xfer_start;
   assign xfer_words  = regs_ff.words;
   assign feed_req    = regs_ff.feed_req;
   assign reader_mode = regs_ff.mode;
   assign cards_owed  = regs_ff.owed;

endmodule

`default_nettype wire

// *** tb/cfs_card_side.sv ***
// card side model: answers feed and transfer requests
`timescale 1ns/1ps
`default_nettype none
module cfs_card_side
(
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic       slow,
   input  wire logic       feed_req,
   input  wire logic       xfer_start,
   input  wire logic [6:0] xfer_words,
   output logic            feed_done,
   output logic            xfer_done
);
   int feed_cnt;
   int xfer_cnt;

   // one feed at a time; transfer moves one word a cycle
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         feed_cnt  <= 0;
         xfer_cnt  <= 0;
         feed_done <= 1'b0;
         xfer_done <= 1'b0;
      end
      else
      begin
         feed_cnt  <= feed_req ? (slow ? 30 : 2) :
                      (feed_cnt > 0 ? feed_cnt - 1 : 0);
         feed_done <= feed_cnt == 1 && !feed_req;
         xfer_cnt  <= xfer_start ? int'(xfer_words) :
                      (xfer_cnt > 0 ? xfer_cnt - 1 : 0);
         xfer_done <= xfer_cnt == 1 && !xfer_start;
      end
   end
endmodule
`default_nettype wire

// *** tb/cfs_unit_chk.sv ***
// checker: port properties of the card unit function interpreter
`timescale 1ns/1ps
`default_nettype none
module cfs_unit_chk
   import cfs_pkg::*;
#(
   parameter int WCNT_W       = 7,
   parameter int WORDS_XLATE  = 14,
   parameter int WORDS_COLUMN = 27,
   parameter int WORDS_ROW    = 27
)
(
   input wire logic              sys_clk,
   input wire logic              rst_b,
   input wire logic              panel_clear,
   input wire logic              fn_strobe,
   input wire logic [WORD_W-1:0] fn_word,
   input wire logic              out_req,
   input wire logic              attention,
   input wire logic [WORD_W-1:0] status_word,
   input wire logic              status_ack,
   input wire logic [2:0]        buf_cards,
   input wire logic              xfer_start,
   input wire logic [WCNT_W-1:0] xfer_words,
   input wire logic              xfer_done,
   input wire logic              feed_req,
   input wire logic              feed_done,
   input wire logic              err_event,
   input wire logic [CODE_W-1:0] err_code,
   input wire logic [1:0]        reader_mode,
   input wire logic [2:0]        cards_owed
);
   // ==========================================================
   // decoded request
   logic [5:0]        base;
   logic              take;
   logic              bad;
   logic              fmt;
   logic [WCNT_W-1:0] nw;
   logic [3:0]        code;

   // base code, accepted strobe, words per card for the mode
   assign base = fn_word[OP_HI:OP_LO] & 6'h37;
   assign take = fn_strobe && out_req;
   assign fmt  = base inside {OP_RDR_XLATE, OP_RDR_COLUMN, OP_RDR_ROW};
   assign bad  = !(fmt || base inside {OP_TERMINATE, OP_XFER_NOFEED,
                                      OP_XFER_FILL, OP_FEED_ONE});
   assign nw   = reader_mode == 2'h0 ? WCNT_W'(WORDS_XLATE) :
                 reader_mode == 2'h1 ? WCNT_W'(WORDS_COLUMN) :
                 WCNT_W'(WORDS_ROW);
   assign code = status_word[CODE_HI:CODE_LO];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   property p_place; attention |-> status_word[31:0] == 32'h0; endproperty
   a_place: assert property (p_place)
      else $error("status word low bits not zero");
   property p_words; xfer_start |-> xfer_words == nw; endproperty
   a_words: assert property (p_words)
      else $error("word count does not follow mode");
   property p_bad;
      take && bad && !err_event |=>
         attention && code == CC_ILLEGAL_OP && !xfer_start && !feed_req;
   endproperty
   a_bad: assert property (p_bad)
      else $error("illegal code not reported");
   property p_fill;
      take && base == OP_XFER_FILL && cards_owed == 3'h0 |=>
         xfer_start && cards_owed == FILL_TOTAL - $past(buf_cards);
   endproperty
   a_fill: assert property (p_fill)
      else $error("fill owed count wrong");
   property p_nofeed;
      take && base == OP_XFER_NOFEED && buf_cards != 3'h0 &&
         cards_owed == 3'h0 |=> xfer_start ##0 !feed_req [*4];
   endproperty
   a_nofeed: assert property (p_nofeed)
      else $error("transfer without feed fed a card");
   property p_one;
      take && base == OP_FEED_ONE && !feed_done &&
         cards_owed inside {3'h1, 3'h2} |=> cards_owed == 3'h1;
   endproperty
   a_one: assert property (p_one)
      else $error("single feed with owed cards");
   property p_dec;
      feed_done && cards_owed != 3'h0 && !fn_strobe |=>
         cards_owed == $past(cards_owed) - 3'h1;
   endproperty
   a_dec: assert property (p_dec)
      else $error("owed count did not step down");
   property p_term;
      fn_strobe && base == OP_TERMINATE |=>
         cards_owed == 3'h0 && !xfer_start && (out_req || attention);
   endproperty
   a_term: assert property (p_term)
      else $error("terminate did not end operation");
   property p_mode;
      take && fmt && !panel_clear |=>
         reader_mode == 2'($past(base) - 6'h32);
   endproperty
   a_mode: assert property (p_mode)
      else $error("reader mode not set");
   property p_form;
      take && fmt && !err_event |=>
         attention == $past(fn_word[OP_LO+INTR_BIT]) &&
         (!attention || code == CC_NORMAL);
   endproperty
   a_form: assert property (p_form)
      else $error("status presence wrong for form");
   property p_clear; panel_clear |=> reader_mode == 2'h0; endproperty
   a_clear: assert property (p_clear)
      else $error("panel clear kept image mode");
   property p_wins;
      take && fmt && fn_word[OP_LO+INTR_BIT] && err_event |=>
         attention && code == $past(err_code);
   endproperty
   a_wins: assert property (p_wins)
      else $error("normal code beat error code");

   c_bad: cover property (attention && code == CC_ILLEGAL_OP);
   c_fill: cover property (take && base == OP_XFER_FILL);
   c_one: cover property (take && base == OP_FEED_ONE);
endmodule
`default_nettype wire

// *** tb/cfs_unit_tb.sv ***
// testbench: self-checking scenarios for the card unit
`timescale 1ns/1ps
`default_nettype none
module cfs_unit_tb
   import cfs_pkg::*;
;
   logic        sys_clk, rst_b, panel_clear, fn_strobe, status_ack;
   logic [35:0] fn_word, status_word;
   logic        out_req, attention, xfer_start, xfer_done, slow;
   logic        feed_req, feed_done, err_event;
   logic [2:0]  buf_cards, cards_owed;
   logic [6:0]  xfer_words;
   logic [3:0]  err_code;
   logic [1:0]  reader_mode;
   int          n_mismatch, checks_done, n_fed, n0;

   cfs_unit i_dut (.sys_clk, .rst_b, .panel_clear, .fn_strobe, .fn_word,
      .out_req, .attention, .status_word, .status_ack, .buf_cards,
      .xfer_start, .xfer_words, .xfer_done, .feed_req, .feed_done,
      .err_event, .err_code, .reader_mode, .cards_owed);
   cfs_card_side i_card (.sys_clk, .rst_b, .slow, .feed_req, .xfer_start,
      .xfer_words, .feed_done, .xfer_done);

   // ==========================================================
   // clock and feed counter
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
      if (feed_done === 1'b1)
         n_fed <= n_fed + 1;

   task automatic end_of_test();
      if (n_mismatch == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [35:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // bounded wait: 0 status up, 1 idle and nothing owed, 2 two owed
   task automatic wait_for(input int w);
      for (int i = 0; i < 500; i++)
      begin
         if ((w == 0 ? attention : w == 1 ? out_req && cards_owed == 0 :
              cards_owed == 3'h2) === 1'b1)
            return;
         @(posedge sys_clk);
         #1;
      end
      n_mismatch++;
      end_of_test();
   endtask
   task automatic send(input logic [5:0] op, input logic [3:0] ec);
      @(posedge sys_clk);
      fn_strobe <= 1'b1;
      fn_word   <= {op, 30'h0};
      err_event <= ec != 4'h0;
      err_code  <= ec;
      @(posedge sys_clk);
      fn_strobe <= 1'b0;
      err_event <= 1'b0;
      #1;
   endtask
   task automatic expect_status(input logic [3:0] code);
      wait_for(0);
      check("completion code", 36'(status_word[35:32]), 36'(code));
      @(posedge sys_clk);
      status_ack <= 1'b1;
      @(posedge sys_clk);
      status_ack <= 1'b0;
      #1;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_modes();
      for (int m = 0; m < 3; m++)
      begin
         send(6'h3a + 6'(m), 4'h0);
         expect_status(CC_NORMAL);
         check("reader mode", 36'(reader_mode), 36'(m));
      end
      send(OP_RDR_COLUMN, 4'h0);
      check("no status", 36'(attention), 36'h0);
      check("column mode", 36'(reader_mode), 36'h1);
   endtask
   task automatic t_fills();
      n0 = n_fed;
      send(6'h2a, 4'h0);
      expect_status(CC_NORMAL);
      wait_for(1);
      check("cards fed empty", 36'(n_fed - n0), 36'h4);
      slow      <= 1'b1;
      buf_cards <= 3'h1;
      send(6'h2a, 4'h0);
      expect_status(CC_NORMAL);
      wait_for(2);
      n0 = n_fed;
      send(6'h2b, 4'h0);
      check("owed after one", 36'(cards_owed), 36'h1);
      expect_status(CC_NORMAL);
      wait_for(1);
      check("cards fed one", 36'(n_fed - n0), 36'h1);
      slow <= 1'b0;
   endtask
   task automatic t_errors();
      logic [5:0] bad_ops [3] = '{6'h0a, 6'h3f, 6'h1f};
      foreach (bad_ops[k])
      begin
         send(bad_ops[k], 4'h0);
         expect_status(CC_ILLEGAL_OP);
      end
      buf_cards <= 3'h0;
      send(6'h29, 4'h0);
      expect_status(CC_INAPPROP);
      send(6'h3b, CC_INTERLOCK);
      expect_status(CC_INTERLOCK);
      buf_cards <= 3'h3;
      send(OP_XFER_NOFEED, 4'h0);
      send(6'h00, CC_CHECK);
      check("held during transfer", 36'(attention), 36'h0);
      expect_status(CC_CHECK);
      repeat (5) @(posedge sys_clk);
      #1;
      check("halted", 36'(out_req), 36'h0);
      send(6'h1b, 4'h0); // sent only after the transfer ended
      expect_status(CC_NORMAL);
      @(posedge sys_clk);
      #1;
      check("ready after end", 36'(out_req), 36'h1);
   endtask

   initial
   begin
      {rst_b, panel_clear, fn_strobe, status_ack, err_event, slow} = '0;
      {fn_word, err_code} = '0;
      buf_cards = 3'h0;
      n_fed = 0;
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      #1;
      check("reset status", status_word, 36'h800000000);
      check("reset mode", 36'(reader_mode), 36'h0);
      send(OP_TERMINATE, 4'h0);
      check("ready", 36'(out_req), 36'h1);
      t_modes();
      t_fills();
      @(posedge sys_clk);
      panel_clear <= 1'b1;
      @(posedge sys_clk);
      panel_clear <= 1'b0;
      #1;
      check("cleared mode", 36'(reader_mode), 36'h0);
      t_errors();
      end_of_test();
   end
endmodule

bind cfs_unit cfs_unit_chk #(.WCNT_W(WCNT_W), .WORDS_XLATE(WORDS_XLATE),
   .WORDS_COLUMN(WORDS_COLUMN), .WORDS_ROW(WORDS_ROW)) i_chk (
   .sys_clk(sys_clk), .rst_b(rst_b), .panel_clear(panel_clear),
   .fn_strobe(fn_strobe), .fn_word(fn_word), .out_req(out_req),
   .attention(attention), .status_word(status_word),
   .status_ack(status_ack), .buf_cards(buf_cards),
   .xfer_start(xfer_start), .xfer_words(xfer_words),
   .xfer_done(xfer_done), .feed_req(feed_req), .feed_done(feed_done),
   .err_event(err_event), .err_code(err_code),
   .reader_mode(reader_mode), .cards_owed(cards_owed));
`default_nettype wire
